// ### verilog/dsm_top.sv
// dsm_top: timeslot monitor taps and elastic store realign commands of one framer.
// assumes: host port is synchronous to clk_i; elastic stores report their
// pointer gap in bytes and move pointers on a realign pulse.
// assumes: stream strobes come from logic on clk_i, so no synchroniser here.
// hazard: a realign moves live pointers; bytes in flight may be lost then.
// limitation: the transmit select arrives as a level; its register lives elsewhere.
//
// Contract
// (RQ1) tap register holds first transmitted bit in msb, last in lsb.
// (RQ2) select value n picks channel n+1; selected slot shows in its tap.
// (RQ3) common_control_five bits 4..0 are the receive tap select.
// (RQ4) rising bit 6 or bit 5 starts a realign check of that store.
// (RQ5) gap of half a frame or more: pointers left alone.
// (RQ6) gap below half a frame: pointers moved half a frame apart.
// (RQ7) software triggers realign only once the backplane clock is stable.
// (RQ8) a held one gives one realign; clear then set for another.
// (RQ9) receive tap register holds the selected receive slot.
// (RQ10) taps reload whole bytes at slot end, once per frame.
`timescale 1ns/1ps
module dsm_top (
  input wire logic clk_i,                          // 100 MHz clock
  input wire logic srst_i,                         // synchronous reset, high
  input wire dsm_pkg::dsm_host_req_t host_i,       // host register access
  output logic [7:0] rdata_o,                      // read data, one cycle after rd
  input wire dsm_pkg::dsm_stream_t tx_strm_i,      // transmit path bits
  input wire dsm_pkg::dsm_stream_t rx_strm_i,      // receive path bits
  input wire logic [4:0] tx_tap_select_i,          // transmit slot select
  input wire logic [dsm_pkg::DSM_GAP_W-1:0] rx_es_gap_i, // rx store pointer gap
  input wire logic [dsm_pkg::DSM_GAP_W-1:0] tx_es_gap_i, // tx store pointer gap
  output logic rx_buffer_realign_o,                // pulse: move rx pointers
  output logic tx_buffer_realign_o                 // pulse: move tx pointers
);
  import dsm_pkg::*;

  dsm_ctl_state_t st_reg;
  dsm_ctl_state_t st_next;
  logic [7:0] tx_timeslot_tap;
  logic [7:0] rx_timeslot_tap;
  logic [7:0] common_control_five;
  logic ctrl_five_wr;
  logic addr_mapped;
  logic rx_edge;
  logic tx_edge;

  // ==========================================================================
  // realign decision
  // fires only on a zero to one change and a gap short of half a frame
  // compared against the stored bit, not the last write, so a held one
  // never retriggers however often software rewrites it
  function automatic logic dsm_need_align(input logic new_bit, input logic old_bit,
                                          input logic [DSM_GAP_W-1:0] gap);
    dsm_need_align = new_bit && !old_bit && (gap < DSM_HALF_FRAME_BYTES);
  endfunction : dsm_need_align

  // ==========================================================================
  // timeslot taps
  // transmit tap follows the select port directly
  dsm_tap u_tx_tap (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .strm_i(tx_strm_i),
    .sel_i(tx_tap_select_i),
    .tap_o(tx_timeslot_tap)
  );

  // receive tap steered by the control register
  dsm_tap u_rx_tap (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .strm_i(rx_strm_i),
    .sel_i(st_reg.rx_sel), // see (RQ3) (RQ9)
    .tap_o(rx_timeslot_tap)
  );

  // ==========================================================================
  // register file
  // bit 7 unassigned, reads zero
  assign common_control_five = {1'b0, st_reg.rx_align, st_reg.tx_align, st_reg.rx_sel};
  // only the control register is writable, tap addresses ignore writes
  assign ctrl_five_wr = host_i.wr && (host_i.addr == DSM_ADDR_CTRL_FIVE);
  assign rx_edge = ctrl_five_wr && host_i.wdata[DSM_RX_ALIGN_BIT] && !st_reg.rx_align;
  assign tx_edge = ctrl_five_wr && host_i.wdata[DSM_TX_ALIGN_BIT] && !st_reg.tx_align;
  // decoded addresses, all others read as the filler value
  assign addr_mapped = (host_i.addr == DSM_ADDR_TX_TAP) || (host_i.addr == DSM_ADDR_CTRL_FIVE) ||
                       (host_i.addr == DSM_ADDR_RX_TAP);

  // next state: writes, realign pulses, read data
  always_comb begin
    st_next = st_reg;
    // pulses default low so each lasts exactly one cycle
    st_next.rx_pulse = 1'b0;
    st_next.tx_pulse = 1'b0;
    if (ctrl_five_wr) begin
      st_next.rx_sel = host_i.wdata[DSM_SEL_MSB:DSM_SEL_LSB]; // see (RQ3)
      st_next.rx_align = host_i.wdata[DSM_RX_ALIGN_BIT];
      st_next.tx_align = host_i.wdata[DSM_TX_ALIGN_BIT];
      // edge only, a held one never repeats
      st_next.rx_pulse = dsm_need_align(host_i.wdata[DSM_RX_ALIGN_BIT], st_reg.rx_align,
                                        rx_es_gap_i); // see (RQ4) (RQ5) (RQ6) (RQ8)
      st_next.tx_pulse = dsm_need_align(host_i.wdata[DSM_TX_ALIGN_BIT], st_reg.tx_align,
                                        tx_es_gap_i); // see (RQ4) (RQ5) (RQ6) (RQ8)
    end
    // a read in the same cycle as a write returns the old value
    if (host_i.rd) begin
      unique case (host_i.addr)
        DSM_ADDR_TX_TAP: st_next.rdata = tx_timeslot_tap; // see (RQ1)
        DSM_ADDR_CTRL_FIVE: st_next.rdata = common_control_five; // see (RQ3)
        DSM_ADDR_RX_TAP: st_next.rdata = rx_timeslot_tap; // see (RQ9)
        default: st_next.rdata = DSM_UNMAPPED_DATA;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_reg <= '0;
      st_reg.rx_sel <= DSM_CTRL_FIVE_RST[DSM_SEL_MSB:DSM_SEL_LSB];
      st_reg.rx_align <= DSM_CTRL_FIVE_RST[DSM_RX_ALIGN_BIT];
      st_reg.tx_align <= DSM_CTRL_FIVE_RST[DSM_TX_ALIGN_BIT];
      st_reg.rdata <= DSM_RDATA_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs
  // straight from flops, so no glitch reaches the elastic stores
  assign rdata_o = st_reg.rdata;
  assign rx_buffer_realign_o = st_reg.rx_pulse;
  assign tx_buffer_realign_o = st_reg.tx_pulse;

  // ==========================================================================
  // checks
  rx_align_fire_a: assert property (@(posedge clk_i) disable iff (srst_i) // see (RQ6)
    (rx_edge && rx_es_gap_i < DSM_HALF_FRAME_BYTES) |=> rx_buffer_realign_o)
    else $error("rx realign missed");
  tx_align_fire_a: assert property (@(posedge clk_i) disable iff (srst_i) // see (RQ6)
    (tx_edge && tx_es_gap_i < DSM_HALF_FRAME_BYTES) |=> tx_buffer_realign_o)
    else $error("tx realign missed");
  rx_gap_ok_a: assert property (@(posedge clk_i) disable iff (srst_i) // see (RQ5)
    !(rx_edge && rx_es_gap_i < DSM_HALF_FRAME_BYTES) |=> !rx_buffer_realign_o)
    else $error("rx realign without cause");
  tx_gap_ok_a: assert property (@(posedge clk_i) disable iff (srst_i) // see (RQ5)
    !(tx_edge && tx_es_gap_i < DSM_HALF_FRAME_BYTES) |=> !tx_buffer_realign_o)
    else $error("tx realign without cause");
  held_one_a: assert property (@(posedge clk_i) disable iff (srst_i) // see (RQ8)
    (st_reg.rx_align && $stable(st_reg.rx_align)) |=> !rx_buffer_realign_o)
    else $error("held rx bit repeated realign");
  rx_sel_wr_a: assert property (@(posedge clk_i) disable iff (srst_i) // see (RQ3)
    ctrl_five_wr |=> st_reg.rx_sel == $past(host_i.wdata[DSM_SEL_MSB:DSM_SEL_LSB]))
    else $error("rx select not written");
  tap_read_a: assert property (@(posedge clk_i) disable iff (srst_i) // see (RQ1)
    (host_i.rd && host_i.addr == DSM_ADDR_TX_TAP) |=> rdata_o == $past(tx_timeslot_tap))
    else $error("tx tap read wrong");
  rx_tap_read_a: assert property (@(posedge clk_i) disable iff (srst_i) // see (RQ9)
    (host_i.rd && host_i.addr == DSM_ADDR_RX_TAP) |=> rdata_o == $past(rx_timeslot_tap))
    else $error("rx tap read wrong");
  ctl_read_a: assert property (@(posedge clk_i) disable iff (srst_i) // see (RQ3)
    (host_i.rd && host_i.addr == DSM_ADDR_CTRL_FIVE) |=> rdata_o == $past(common_control_five))
    else $error("control read wrong");
  // unmapped reads return the filler value
  unmapped_read_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (host_i.rd && !addr_mapped) |=> rdata_o == DSM_UNMAPPED_DATA)
    else $error("unmapped read not filler");
  // read data stands until the next read
  rdata_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
    !host_i.rd |=> $stable(rdata_o))
    else $error("read data changed without read");

  // ==========================================================================
  // checks: control writes
  // select changes on control writes only
  rx_sel_hold_a: assert property (@(posedge clk_i) disable iff (srst_i) // see (RQ3)
    !ctrl_five_wr |=> $stable(st_reg.rx_sel))
    else $error("rx select changed without write");
  // writes to the read-only taps leave control alone
  ro_write_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (host_i.wr && host_i.addr != DSM_ADDR_CTRL_FIVE) |=> $stable(common_control_five))
    else $error("control changed by other write");
  // command bits are stored as written, even when no pulse follows
  rx_bit_store_a: assert property (@(posedge clk_i) disable iff (srst_i) // see (RQ8)
    ctrl_five_wr |=> st_reg.rx_align == $past(host_i.wdata[DSM_RX_ALIGN_BIT]))
    else $error("rx command bit not stored");
  tx_bit_store_a: assert property (@(posedge clk_i) disable iff (srst_i) // see (RQ8)
    ctrl_five_wr |=> st_reg.tx_align == $past(host_i.wdata[DSM_TX_ALIGN_BIT]))
    else $error("tx command bit not stored");

  // ==========================================================================
  // checks: realign pulses
  // a rewritten one on transmit gives no second pulse
  tx_held_one_a: assert property (@(posedge clk_i) disable iff (srst_i) // see (RQ8)
    (ctrl_five_wr && host_i.wdata[DSM_TX_ALIGN_BIT] && st_reg.tx_align) |=> !tx_buffer_realign_o)
    else $error("held tx bit repeated realign");
  // pulses last one cycle
  rx_pulse_once_a: assert property (@(posedge clk_i) disable iff (srst_i) // see (RQ8)
    rx_buffer_realign_o |=> !rx_buffer_realign_o)
    else $error("rx pulse too long");
  tx_pulse_once_a: assert property (@(posedge clk_i) disable iff (srst_i) // see (RQ8)
    tx_buffer_realign_o |=> !tx_buffer_realign_o)
    else $error("tx pulse too long");
  // a pulse only follows a stored one
  rx_pulse_cause_a: assert property (@(posedge clk_i) disable iff (srst_i) // see (RQ4)
    rx_buffer_realign_o |-> st_reg.rx_align)
    else $error("rx pulse without command bit");
  tx_pulse_cause_a: assert property (@(posedge clk_i) disable iff (srst_i) // see (RQ4)
    tx_buffer_realign_o |-> st_reg.tx_align)
    else $error("tx pulse without command bit");
  // no pulse without a control write
  align_on_write_a: assert property (@(posedge clk_i) disable iff (srst_i) // see (RQ4)
    !ctrl_five_wr |=> !rx_buffer_realign_o && !tx_buffer_realign_o)
    else $error("realign pulse without write");

  // ==========================================================================
  // checks: reset
  // reset clears read data, pulses and control
  rst_values_a: assert property (@(posedge clk_i)
    srst_i |=> rdata_o == DSM_RDATA_RST && !rx_buffer_realign_o && !tx_buffer_realign_o &&
               common_control_five == DSM_CTRL_FIVE_RST)
    else $error("reset values wrong");

endmodule : dsm_top

// ### verilog/dsm_pkg.sv
// dsm_pkg: constants, register map and carrier types for the timeslot tap
// and elastic store realign block.
// assumes: one 100 MHz clock; all users import this package.
package dsm_pkg;

  // ==========================================================================
  // register map of the host port
  localparam logic [7:0] DSM_ADDR_TX_TAP = 8'hA9;
  localparam logic [7:0] DSM_ADDR_CTRL_FIVE = 8'hAA;
  localparam logic [7:0] DSM_ADDR_RX_TAP = 8'hAB;

  // ==========================================================================
  // field positions of common_control_five
  localparam int DSM_SEL_LSB = 0;
  localparam int DSM_SEL_MSB = 4;
  localparam int DSM_TX_ALIGN_BIT = 5;
  localparam int DSM_RX_ALIGN_BIT = 6;

  // ==========================================================================
  // reset values
  localparam logic [7:0] DSM_CTRL_FIVE_RST = 8'h00;
  localparam logic [7:0] DSM_TAP_RST = 8'h00;
  localparam logic [7:0] DSM_RDATA_RST = 8'h00;
  localparam logic [7:0] DSM_UNMAPPED_DATA = 8'h00;

  // ==========================================================================
  // frame geometry
  localparam int DSM_GAP_W = 6;
  localparam logic [DSM_GAP_W-1:0] DSM_HALF_FRAME_BYTES = 6'h10;
  localparam logic [2:0] DSM_LAST_BIT = 3'h7;
  localparam logic [2:0] DSM_FIRST_BIT = 3'h0;
  localparam logic [7:0] DSM_BIT_POS_RST = 8'h00;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic frame_start; // marks the first bit of a frame
    logic bit_en;      // one bit is present this cycle
    logic bit_val;     // value of that bit
  } dsm_stream_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } dsm_host_req_t;

  typedef struct packed {
    logic [7:0] pos;   // next bit position in the frame
    logic [7:0] shift; // bits of the current timeslot
    logic first_bit;   // first bit of the selected slot
    logic [7:0] tap;   // last complete selected slot
  } dsm_tap_state_t;

  typedef struct packed {
    logic [4:0] rx_sel;
    logic rx_align;
    logic tx_align;
    logic rx_pulse;
    logic tx_pulse;
    logic [7:0] rdata;
  } dsm_ctl_state_t;

endpackage : dsm_pkg

// ### verilog/dsm_tap.sv
// dsm_tap: copies one selected timeslot of a serial frame into a byte register.
// assumes: stream strobes come from logic on clk_i; frame_start is given with
// the first bit of each frame.
`timescale 1ns/1ps
module dsm_tap (
  input wire logic clk_i,                  // 100 MHz clock
  input wire logic srst_i,                 // synchronous reset, high
  input wire dsm_pkg::dsm_stream_t strm_i, // serial bit stream
  input wire logic [4:0] sel_i,            // slot select, 0 = channel 1
  output logic [7:0] tap_o                 // last complete selected slot
);
  import dsm_pkg::*;

  dsm_tap_state_t st_reg;
  dsm_tap_state_t st_next;
  logic [7:0] pos;
  logic hit_last;
  logic [7:0] cap_val;

  // ==========================================================================
  // bit position and slot capture
  // position restarts on the frame mark
  assign pos = strm_i.frame_start ? DSM_BIT_POS_RST : st_reg.pos;
  // last bit of the selected slot, 0 picks channel 1
  assign hit_last = strm_i.bit_en && (pos[2:0] == DSM_LAST_BIT) && (pos[7:3] == sel_i); // see (RQ2)
  // first bit lands in the msb
  assign cap_val = {st_reg.shift[6:0], strm_i.bit_val}; // see (RQ1)

  // next state
  always_comb begin
    st_next = st_reg;
    if (strm_i.bit_en) begin
      st_next.pos = pos + 8'h01;
      st_next.shift = cap_val;
      if ((pos[2:0] == DSM_FIRST_BIT) && (pos[7:3] == sel_i)) begin
        st_next.first_bit = strm_i.bit_val;
      end
    end
    // whole byte loaded at slot end only
    if (hit_last) begin
      st_next.tap = cap_val; // see (RQ10)
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_reg <= '0;
      st_reg.tap <= DSM_TAP_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tap_o = st_reg.tap;

  // ==========================================================================
  // checks
  tap_load_a: assert property (@(posedge clk_i) disable iff (srst_i) // see (RQ10)
    hit_last |=> tap_o == $past(cap_val)) else $error("tap not loaded at slot end");
  tap_hold_a: assert property (@(posedge clk_i) disable iff (srst_i) // see (RQ10)
    !hit_last |=> $stable(tap_o)) else $error("tap changed mid slot");
  tap_msb_first_a: assert property (@(posedge clk_i) disable iff (srst_i) // see (RQ1)
    hit_last |=> tap_o[7] == $past(st_reg.first_bit) && tap_o[0] == $past(strm_i.bit_val))
    else $error("tap bit order wrong");

endmodule : dsm_tap

// ### testbench/dsm_top_tb.sv
// dsm_top_tb: self-checking bench for the timeslot taps and realign commands.
// assumes: dsm_pkg and dsm_top are compiled first; host strobes are one cycle wide.
`timescale 1ns/1ps
module dsm_top_tb;
  import dsm_pkg::*;

  // ==========================================================================
  // signals
  logic clk_i;
  logic srst_i;
  dsm_host_req_t host_i;
  logic [7:0] rdata_o;
  dsm_stream_t tx_strm_i;
  dsm_stream_t rx_strm_i;
  logic [4:0] tx_tap_select_i;
  logic [DSM_GAP_W-1:0] rx_es_gap_i;
  logic [DSM_GAP_W-1:0] tx_es_gap_i;
  logic rx_buffer_realign_o;
  logic tx_buffer_realign_o;
  int mismatches;
  int compares;
  logic [4:0] sel_tab [3] = '{5'h00, 5'h0E, 5'h1F};

  dsm_top dut (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .host_i(host_i),
    .rdata_o(rdata_o),
    .tx_strm_i(tx_strm_i),
    .rx_strm_i(rx_strm_i),
    .tx_tap_select_i(tx_tap_select_i),
    .rx_es_gap_i(rx_es_gap_i),
    .tx_es_gap_i(tx_es_gap_i),
    .rx_buffer_realign_o(rx_buffer_realign_o),
    .tx_buffer_realign_o(tx_buffer_realign_o)
  );

  // clock of 10 ns
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ==========================================================================
  // slot contents: distinct per slot and per direction
  function automatic logic [7:0] tx_byte(input logic [4:0] s);
    return {s, 3'h5};
  endfunction : tx_byte

  function automatic logic [7:0] rx_byte(input logic [4:0] s);
    return {3'h6, s};
  endfunction : rx_byte

  // ==========================================================================
  // compare, host access and stream tasks
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_pulse(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_pulse

  task automatic host_wr(input logic [7:0] a, input logic [7:0] d);
    host_i.addr = a;
    host_i.wdata = d;
    host_i.wr = 1'b1;
    @(posedge clk_i);
    #1;
    host_i.wr = 1'b0;
  endtask : host_wr

  task automatic host_rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    host_i.addr = a;
    host_i.rd = 1'b1;
    @(posedge clk_i);
    #1;
    host_i.rd = 1'b0;
    chk(what, exp, rdata_o);
    // let an edge pass so a following read raises rd in a fresh step
    @(posedge clk_i);
    #1;
  endtask : host_rd

  // write control and check both pulses for one cycle, then quiet
  task automatic wr_chk(input logic [7:0] d, input logic ex_rx, input logic ex_tx);
    host_wr(DSM_ADDR_CTRL_FIVE, d);
    chk_pulse("rx_pulse", ex_rx, rx_buffer_realign_o);
    chk_pulse("tx_pulse", ex_tx, tx_buffer_realign_o);
    @(posedge clk_i);
    #1;
    chk_pulse("rx_pulse_end", 1'b0, rx_buffer_realign_o);
    chk_pulse("tx_pulse_end", 1'b0, tx_buffer_realign_o);
  endtask : wr_chk

  // one whole frame on both paths, first bit of each slot first
  task automatic send_frame();
    logic [7:0] tx_slot;
    logic [7:0] rx_slot;
    for (int p = 0; p < 256; p++) begin
      tx_slot = tx_byte(5'(p >> 3));
      rx_slot = rx_byte(5'(p >> 3));
      tx_strm_i = '{frame_start: (p == 0), bit_en: 1'b1, bit_val: tx_slot[7 - (p % 8)]};
      rx_strm_i = '{frame_start: (p == 0), bit_en: 1'b1, bit_val: rx_slot[7 - (p % 8)]};
      @(posedge clk_i);
      #1;
    end
    tx_strm_i = '{frame_start: 1'b0, bit_en: 1'b0, bit_val: 1'b1};
    rx_strm_i = '{frame_start: 1'b0, bit_en: 1'b0, bit_val: 1'b1};
  endtask : send_frame

  task automatic print_verdict();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  // ==========================================================================
  // watchdog, well beyond the few frames sent
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    print_verdict();
  end

  // main sequence
  initial begin
    mismatches = 0;
    compares = 0;
    host_i = '0;
    tx_strm_i = '0;
    rx_strm_i = '0;
    tx_tap_select_i = 5'h00;
    rx_es_gap_i = 6'h10;
    tx_es_gap_i = 6'h10;
    srst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    #1;
    srst_i = 1'b0;
    host_rd(DSM_ADDR_TX_TAP, DSM_TAP_RST, "tx_tap_rst");
    host_rd(DSM_ADDR_CTRL_FIVE, DSM_CTRL_FIVE_RST, "ctl_rst");
    host_rd(DSM_ADDR_RX_TAP, DSM_TAP_RST, "rx_tap_rst");
    host_rd(8'h55, DSM_UNMAPPED_DATA, "unmapped");
    // boundary and middle select values on both paths
    foreach (sel_tab[i]) begin
      host_wr(DSM_ADDR_CTRL_FIVE, {3'h0, sel_tab[i]});
      tx_tap_select_i = ~sel_tab[i];
      send_frame();
      host_rd(DSM_ADDR_TX_TAP, tx_byte(~sel_tab[i]), "tx_tap");
      host_rd(DSM_ADDR_RX_TAP, rx_byte(sel_tab[i]), "rx_tap");
      host_rd(DSM_ADDR_CTRL_FIVE, {3'h0, sel_tab[i]}, "ctl_sel");
    end
    // realign commands only once the store gaps are driven and settled
    rx_es_gap_i = 6'h05;
    wr_chk(8'h40, 1'b1, 1'b0);
    wr_chk(8'h40, 1'b0, 1'b0);
    wr_chk(8'h00, 1'b0, 1'b0);
    rx_es_gap_i = 6'h10;
    wr_chk(8'h40, 1'b0, 1'b0);
    tx_es_gap_i = 6'h0F;
    wr_chk(8'h20, 1'b0, 1'b1);
    wr_chk(8'hFF, 1'b0, 1'b0);
    host_rd(DSM_ADDR_CTRL_FIVE, 8'h7F, "ctl_bit7");
    host_wr(DSM_ADDR_TX_TAP, 8'hFF);
    host_rd(DSM_ADDR_TX_TAP, tx_byte(5'h00), "tx_tap_ro");
    // clear then set again rearms the receive realign
    rx_es_gap_i = 6'h05;
    wr_chk(8'h00, 1'b0, 1'b0);
    wr_chk(8'h40, 1'b1, 1'b0);
    // mid-run reset clears control, taps and read data
    srst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    srst_i = 1'b0;
    host_rd(DSM_ADDR_CTRL_FIVE, DSM_CTRL_FIVE_RST, "ctl_rst2");
    host_rd(DSM_ADDR_TX_TAP, DSM_TAP_RST, "tx_tap_rst2");
    host_rd(DSM_ADDR_RX_TAP, DSM_TAP_RST, "rx_tap_rst2");
    print_verdict();
  end

endmodule : dsm_top_tb
